// *** verif/proximity_threshold_control_tb_top.sv ***
`timescale 1ns/1ns
module proximity_threshold_control_tb_top;
	localparam int SSTEP = 4;
	localparam int WSTEP = 3;
	localparam logic [7:0] OFFS [8] =
		'{8'h80, 8'h82, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h81};
	localparam logic [7:0] RSTV [8] =
		'{8'h00, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] MASK [8] =
		'{8'h00, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h3f, 8'h0f, 8'hff};

	logic        ref_clk      = 1'h0;
	logic        arst_n       = 1'h0;
	logic [7:0]  reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        prox_valid;
	logic [13:0] prox_result;
	logic        osc_adc_on;
	logic        detect_active;
	logic        wait_active;
	logic        sample_end;
	logic        apc_enable;
	logic        prox_event;
	logic        low_breach;
	logic        high_breach;
	logic        rd_d         = 1'h0;
	logic        vld_d        = 1'h0;
	logic [7:0]  rq [$];
	logic [2:0]  pq [$];
	logic [2:0]  ev;
	logic [7:0]  d;
	logic [13:0] v;
	int          seed         = 50;
	int          err_count    = 0;
	int          total_checks = 0;

	ptc_top #(.SAMPLE_STEP_CYC(SSTEP), .WAIT_STEP_CYC(WSTEP)) uut (
		.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .prox_valid(prox_valid),
		.prox_result(prox_result), .osc_adc_on(osc_adc_on),
		.detect_active(detect_active), .wait_active(wait_active),
		.sample_end(sample_end), .apc_enable(apc_enable),
		.prox_event(prox_event), .low_breach(low_breach),
		.high_breach(high_breach));

	ptc_host_model host (
		.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.prox_valid(prox_valid), .prox_result(prox_result));

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	// ****************************************
	// checking helpers
	// ****************************************
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s: expected %h, seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] dv);
		host.xfer(1'h1, a, dv);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		host.xfer(1'h0, a, 8'h00);
	endtask

	task automatic res(input logic [13:0] r, input logic [2:0] e);
		pq.push_back(e);
		host.sample(r);
	endtask

	// cycles from one sample end to the next, or wait cycles among them
	task automatic span(input logic w, input logic [15:0] e);
		int n;
		int c;
		n = 0;
		c = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (sample_end !== 1'h1 && n < 3000);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
			c += (!w || wait_active === 1'h1) ? 1 : 0;
		end while (sample_end !== 1'h1 && n < 3000);
		chk(w ? "wait_len" : "sample_len", e, 16'(c));
	endtask

	task automatic done_test(input string n);
		$display("test %s done", n);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// result monitor
	// ****************************************
	always @(posedge ref_clk) begin
		rd_d  <= reg_rd;
		vld_d <= prox_valid;
	end

	always @(negedge ref_clk) begin
		if (rd_d) begin
			chk("reg_rdata", 16'(rq.pop_front()), 16'(reg_rdata));
		end
		ev = vld_d ? pq.pop_front() : 3'h0;
		chk("events", 16'(ev),
			16'({prox_event, low_breach, high_breach}));
	end

	initial begin
		#200000;
		err_count++;
		tally_and_finish;
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		repeat (12) @(negedge ref_clk);
		arst_n = 1'h1;
		chk("apc_enable", 16'h1, 16'(apc_enable));
		for (int i = 0; i < 8; i++) begin
			rdc(OFFS[i], RSTV[i]);
		end
		for (int i = 1; i < 8; i++) begin
			d = 8'($random(seed)) & MASK[i];
			wr(OFFS[i], d);
			rdc(OFFS[i], (i == 7) ? 8'h00 : d);
		end
		done_test("registers");
		wr(8'h82, 8'h02);
		wr(8'h8c, 8'h01);
		wr(8'h88, 8'h10);
		wr(8'h89, 8'h01);
		wr(8'h8a, 8'h00);
		wr(8'h8b, 8'h02);
		wr(8'h88, 8'h50);
		wr(8'h80, 8'h01);
		repeat (2) @(negedge ref_clk);
		chk("osc_adc_on", 16'h1, 16'(osc_adc_on));
		chk("detect_active", 16'h0, 16'(detect_active));
		wr(8'h80, 8'h05);
		chk("detect_active", 16'h0, 16'(detect_active));
		repeat (2) @(negedge ref_clk);
		chk("detect_active", 16'h1, 16'(detect_active));
		span(1'h0, 16'((2 + 1) * SSTEP));
		done_test("enable and sample");
		res(14'h0120, 3'h0);
		res(14'h0110, 3'h0);
		res(14'h0200, 3'h0);
		res(14'h010f, 3'h6);
		res(14'h0201, 3'h5);
		res(14'h2000, 3'h5);
		wr(8'h89, 8'h01);
		res(14'h014f, 3'h6);
		wr(8'h8c, 8'h03);
		res(14'h0180, 3'h0);
		for (int k = 0; k < 7; k++) begin
			res(k == 2 ? 14'h0180 : 14'h0100,
				k > 4 ? 3'h6 : 3'h0);
		end
		for (int p = 0; p < 16; p++) begin
			wr(8'h8c, 8'(p));
			v = 14'h0150 + 14'($random(seed) & 8'h7f);
			res(v, {p == 0, 2'h0});
			for (int k = 1; k <= p + 1; k++) begin
				v = 14'h0201 + 14'($random(seed) & 8'hff);
				res(v, (p == 0 || k >= p) ? 3'h5 : 3'h0);
			end
		end
		done_test("thresholds and persistence");
		wr(8'hae, 8'h7f);
		wr(8'h8a, 8'hc0);
		wr(8'h8c, 8'h01);
		chk("apc_enable", 16'h0, 16'(apc_enable));
		res(14'h0300, 3'h0);
		res(14'h0140, 3'h0);
		res(14'h013c, 3'h6);
		res(14'h0304, 3'h5);
		wr(8'hae, 8'h3f);
		done_test("short thresholds");
		wr(8'ha9, 8'h01);
		wr(8'h80, 8'h15);
		span(1'h1, 16'(2 * WSTEP));
		wr(8'h8d, 8'h48);
		span(1'h1, 16'(2 * 12 * WSTEP));
		wr(8'h80, 8'h00);
		repeat (2) @(negedge ref_clk);
		chk("osc_adc_on", 16'h0, 16'(osc_adc_on));
		chk("detect_active", 16'h0, 16'(detect_active));
		chk("wait_active", 16'h0, 16'(wait_active));
		res(14'h3fff, 3'h0);
		done_test("wait and stop");
		arst_n = 1'h0;
		repeat (2) @(negedge ref_clk);
		arst_n = 1'h1;
		rdc(8'h82, 8'h1f);
		rdc(8'h8a, 8'h00);
		repeat (3) @(negedge ref_clk);
		done_test("second reset");
		tally_and_finish;
	end
endmodule

// *** verif/ptc_host_model.sv ***
`timescale 1ns/1ns
// ****************************************
// host register port and adc result source
// ****************************************
module ptc_host_model (
	input  wire logic        ref_clk,
	output logic [7:0]       reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [7:0]       reg_wdata,
	output logic             prox_valid,
	output logic [13:0]      prox_result
);
	initial begin
		reg_addr    = 8'h00;
		reg_wr      = 1'h0;
		reg_rd      = 1'h0;
		reg_wdata   = 8'h00;
		prox_valid  = 1'h0;
		prox_result = 14'h0000;
	end

	// one byte access held across one rising edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = w;
		reg_rd    = !w;
		@(negedge ref_clk);
		reg_wr    = 1'h0;
		reg_rd    = 1'h0;
		// idle bus shows no stale value
		reg_addr  = ~a;
		reg_wdata = ~d;
	endtask

	// one adc result strobe
	task automatic sample(input logic [13:0] v);
		@(negedge ref_clk);
		prox_result = v;
		prox_valid  = 1'h1;
		@(negedge ref_clk);
		prox_valid  = 1'h0;
		prox_result = ~v;
	endtask
endmodule

// *** verilog/ptc_phase_timer.sv ***
`timescale 1ns/1ns
module ptc_phase_timer #(
	parameter int CYC_W = 24,
	parameter int STP_W = 12
) (
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	input  wire logic             restart,
	input  wire logic [CYC_W-1:0] step_cycles,
	input  wire logic [STP_W-1:0] steps,
	output logic                  done
);

	// ****************************************
	// parameter check
	// ****************************************
	if (CYC_W < 1 || STP_W < 1) begin
		$error("timer width parameter out of range");
	end

	// ****************************************
	// prescaler and step counter
	// ****************************************
	logic [CYC_W-1:0] pre;
	logic [STP_W-1:0] stp;
	wire              step_end  = (pre == step_cycles - 1'b1);
	wire              last_step = (stp == steps - 1'b1);
	wire [CYC_W-1:0]  next_pre  = (restart || step_end) ? '0 : pre + 1'b1;
	wire [STP_W-1:0]  next_stp  = (restart || done) ? '0 :
		(step_end ? stp + 1'b1 : stp);

	assign done = step_end && last_step && !restart;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pre <= '0;
			stp <= '0;
		end else begin
			pre <= next_pre;
			stp <= next_stp;
		end
	end

endmodule

// *** verilog/ptc_pkg.sv ***
package ptc_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] OFF_ENABLE    = 8'h80;
	localparam logic [7:0] OFF_RATE      = 8'h82;
	localparam logic [7:0] OFF_LO_LSB    = 8'h88;
	localparam logic [7:0] OFF_LO_MSB    = 8'h89;
	localparam logic [7:0] OFF_HI_LSB    = 8'h8a;
	localparam logic [7:0] OFF_HI_MSB    = 8'h8b;
	localparam logic [7:0] OFF_PERSISTENCE_FILTER      = 8'h8c;
	localparam logic [7:0] OFF_CFG0      = 8'h8d;
	localparam logic [7:0] OFF_WAIT      = 8'ha9;
	localparam logic [7:0] OFF_CONFIG_SIX_REG      = 8'hae;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_ENABLE    = 8'h00;
	localparam logic [7:0] RST_RATE      = 8'h1f;
	localparam logic [7:0] RST_THR       = 8'h00;
	localparam logic [7:0] RST_PERSISTENCE_FILTER      = 8'h00;
	localparam logic [7:0] RST_CFG0      = 8'h40;
	localparam logic [7:0] RST_WAIT      = 8'h00;
	localparam logic [7:0] RST_CONFIG_SIX_REG      = 8'h3f;

	// ****************************************
	// field positions and widths
	// ****************************************
	localparam int BIT_POWER_ON  = 0;
	localparam int BIT_DETECT    = 2;
	localparam int BIT_WAIT      = 4;
	localparam int BIT_WAIT_LONG = 3;
	localparam int BIT_APC_OFF   = 6;
	localparam int PERSISTENCE_FILTER_W        = 4;
	localparam int THR_W         = 14;
	localparam int MSB_W         = 6;
	localparam int SHORT_LSB     = 2;
	localparam int STEPS_W       = 12;
	localparam int CYC_W         = 24;
	localparam logic [11:0] WAIT_LONG_FACTOR = 12'h00c;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS   = 10;
	localparam int SAMPLE_STEP_NS  = 88000;
	localparam int SAMPLE_STEP_CYC =
		(SAMPLE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAIT_STEP_NS    = 1000000;
	localparam int WAIT_STEP_CYC   =
		(WAIT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// sequencer states
	// ****************************************
	typedef enum logic [2:0] {
		PTC_IDLE   = 3'b001,
		PTC_SAMPLE = 3'b010,
		PTC_WAIT   = 3'b100
	} ptc_state_t;

endpackage

// *** verilog/ptc_thr_pair.sv ***
`timescale 1ns/1ns
module ptc_thr_pair (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        wr_lsb,
	input  wire logic        wr_msb,
	input  wire logic [7:0]  wdata,
	output logic [7:0]       lsb,
	output logic [7:0]       msb,
	output logic [13:0]      active
);

	// ****************************************
	// buffered low byte, joint latch on high byte
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lsb    <= ptc_pkg::RST_THR;
			msb    <= ptc_pkg::RST_THR;
			active <= '0;
		end else begin
			if (wr_lsb) begin
				lsb <= wdata;
			end
			if (wr_msb) begin
				msb    <= wdata;
				active <= {wdata[ptc_pkg::MSB_W-1:0], lsb};
			end
		end
	end

endmodule

// *** verilog/ptc_top.sv ***
// Contract
// - power-on bit 0 runs oscillator and ADC; low keeps them off
// - enable bit 2 starts proximity detection cycles; clearing stops them
// - enable bit 4 inserts a wait phase timed by wait-time register
// - one sample lasts (rate field plus one) times 88 microseconds
// - pulse control on: 14-bit thresholds from low byte plus high 5:0
// - pulse control off: upper 8 of 10-bit result against low bytes
// - config six bit 6 set disables pulse control, switching format
// - low breach when result below low threshold and persistence met
// - high breach when result above high threshold and persistence met
// - low byte buffered; both bytes latch together on high byte write; pulse control off compares the low bytes unbuffered
// - persistence 0 every cycle, 1 any out-of-range, 2-15 consecutive
// - count consecutive out-of-range results; event when count equals
// - counter clears whenever a result falls inside the window
// - compared result is the 14-bit prox_result input; only bits 9:2 with pulse control off
// - wait-long bit stretches the wait phase by a factor of twelve
`timescale 1ns/1ns
module ptc_top #(
	parameter int SAMPLE_STEP_CYC = ptc_pkg::SAMPLE_STEP_CYC,
	parameter int WAIT_STEP_CYC   = ptc_pkg::WAIT_STEP_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic [7:0]       reg_rdata,
	input  wire logic        prox_valid,
	input  wire logic [13:0] prox_result,
	output logic             osc_adc_on,
	output logic             detect_active,
	output logic             wait_active,
	output logic             sample_end,
	output logic             apc_enable,
	output logic             prox_event,
	output logic             low_breach,
	output logic             high_breach
);

	// ****************************************
	// parameter check
	// ****************************************
	if (SAMPLE_STEP_CYC < 1 || SAMPLE_STEP_CYC >= (1 << ptc_pkg::CYC_W) ||
	    WAIT_STEP_CYC < 1 || WAIT_STEP_CYC >= (1 << ptc_pkg::CYC_W)) begin
		$error("step cycle parameter out of range");
	end

	// ****************************************
	// register write decode
	// ****************************************
	function automatic logic wr_hit(
		input logic       wr,
		input logic [7:0] addr,
		input logic [7:0] off
	);
		wr_hit = wr && (addr == off);
	endfunction

	wire wr_enable = wr_hit(reg_wr, reg_addr, ptc_pkg::OFF_ENABLE);
	wire wr_rate   = wr_hit(reg_wr, reg_addr, ptc_pkg::OFF_RATE);
	wire wr_lo_lsb = wr_hit(reg_wr, reg_addr, ptc_pkg::OFF_LO_LSB);
	wire wr_lo_msb = wr_hit(reg_wr, reg_addr, ptc_pkg::OFF_LO_MSB);
	wire wr_hi_lsb = wr_hit(reg_wr, reg_addr, ptc_pkg::OFF_HI_LSB);
	wire wr_hi_msb = wr_hit(reg_wr, reg_addr, ptc_pkg::OFF_HI_MSB);
	wire wr_persistence_filter   = wr_hit(reg_wr, reg_addr, ptc_pkg::OFF_PERSISTENCE_FILTER);
	wire wr_cfg0   = wr_hit(reg_wr, reg_addr, ptc_pkg::OFF_CFG0);
	wire wr_wait   = wr_hit(reg_wr, reg_addr, ptc_pkg::OFF_WAIT);
	wire wr_config_six_reg   = wr_hit(reg_wr, reg_addr, ptc_pkg::OFF_CONFIG_SIX_REG);

	// ****************************************
	// control registers
	// ****************************************
	logic [7:0] function_enables;
	logic [7:0] sample_duration;
	logic [7:0] persistence_filter;
	logic [7:0] cfg0_reg;
	logic [7:0] wait_time_reg;
	logic [7:0] config_six_reg;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			function_enables   <= ptc_pkg::RST_ENABLE;
			sample_duration    <= ptc_pkg::RST_RATE;
			persistence_filter <= ptc_pkg::RST_PERSISTENCE_FILTER;
			cfg0_reg           <= ptc_pkg::RST_CFG0;
			wait_time_reg      <= ptc_pkg::RST_WAIT;
			config_six_reg     <= ptc_pkg::RST_CONFIG_SIX_REG;
		end else begin
			if (wr_enable) function_enables <= reg_wdata;
			if (wr_rate) sample_duration <= reg_wdata;
			if (wr_persistence_filter) persistence_filter <= reg_wdata;
			if (wr_cfg0) cfg0_reg <= reg_wdata;
			if (wr_wait) wait_time_reg <= reg_wdata;
			if (wr_config_six_reg) config_six_reg <= reg_wdata;
		end
	end

	wire power_on_bit      = function_enables[ptc_pkg::BIT_POWER_ON];
	wire detect_enable_bit = function_enables[ptc_pkg::BIT_DETECT];
	wire wait_enable_bit   = function_enables[ptc_pkg::BIT_WAIT];
	wire wait_long_bit     = cfg0_reg[ptc_pkg::BIT_WAIT_LONG];
	wire apc_on            = !config_six_reg[ptc_pkg::BIT_APC_OFF];
	wire [ptc_pkg::PERSISTENCE_FILTER_W-1:0] persistence_field =
		persistence_filter[ptc_pkg::PERSISTENCE_FILTER_W-1:0];

	// ****************************************
	// thresholds
	// ****************************************
	logic [7:0]  lo_lsb;
	logic [7:0]  lo_msb;
	logic [13:0] lo_active;
	logic [7:0]  hi_lsb;
	logic [7:0]  hi_msb;
	logic [13:0] hi_active;

	ptc_thr_pair u_lo (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.wr_lsb  (wr_lo_lsb),
		.wr_msb  (wr_lo_msb),
		.wdata   (reg_wdata),
		.lsb     (lo_lsb),
		.msb     (lo_msb),
		.active  (lo_active)
	);

	ptc_thr_pair u_hi (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.wr_lsb  (wr_hi_lsb),
		.wr_msb  (wr_hi_msb),
		.wdata   (reg_wdata),
		.lsb     (hi_lsb),
		.msb     (hi_msb),
		.active  (hi_active)
	);

	// ****************************************
	// read mux
	// ****************************************
	wire [7:0] rd_mux =
		(reg_addr == ptc_pkg::OFF_ENABLE) ? function_enables :
		(reg_addr == ptc_pkg::OFF_RATE)   ? sample_duration :
		(reg_addr == ptc_pkg::OFF_LO_LSB) ? lo_lsb :
		(reg_addr == ptc_pkg::OFF_LO_MSB) ? lo_msb :
		(reg_addr == ptc_pkg::OFF_HI_LSB) ? hi_lsb :
		(reg_addr == ptc_pkg::OFF_HI_MSB) ? hi_msb :
		(reg_addr == ptc_pkg::OFF_PERSISTENCE_FILTER)   ? persistence_filter :
		(reg_addr == ptc_pkg::OFF_CFG0)   ? cfg0_reg :
		(reg_addr == ptc_pkg::OFF_WAIT)   ? wait_time_reg :
		(reg_addr == ptc_pkg::OFF_CONFIG_SIX_REG)   ? config_six_reg : 8'h00;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end
	end

	// ****************************************
	// cycle sequencer
	// ****************************************
	ptc_pkg::ptc_state_t state;
	ptc_pkg::ptc_state_t next_state;
	logic                phase_done;
	wire run       = power_on_bit && detect_enable_bit;
	wire st_idle   = (state == ptc_pkg::PTC_IDLE);
	wire st_sample = (state == ptc_pkg::PTC_SAMPLE);
	wire st_wait   = (state == ptc_pkg::PTC_WAIT);

	always_comb begin
		next_state = state;
		case (state)
			ptc_pkg::PTC_IDLE: begin
				if (run) next_state = ptc_pkg::PTC_SAMPLE;
			end
			ptc_pkg::PTC_SAMPLE: begin
				if (phase_done && wait_enable_bit) begin
					next_state = ptc_pkg::PTC_WAIT;
				end
			end
			ptc_pkg::PTC_WAIT: begin
				if (phase_done || !wait_enable_bit) begin
					next_state = ptc_pkg::PTC_SAMPLE;
				end
			end
			default: next_state = ptc_pkg::PTC_IDLE;
		endcase
		if (!run) next_state = ptc_pkg::PTC_IDLE;
	end

	wire [11:0] sample_steps = {4'h0, sample_duration} + 12'h001;
	wire [11:0] wait_base    = {4'h0, wait_time_reg} + 12'h001;
	wire [23:0] wait_prod    = wait_base * ptc_pkg::WAIT_LONG_FACTOR;
	wire [11:0] wait_steps   = wait_long_bit ? wait_prod[11:0] : wait_base;
	wire [23:0] sample_cyc   = 24'(SAMPLE_STEP_CYC);
	wire [23:0] wait_cyc     = 24'(WAIT_STEP_CYC);

	ptc_phase_timer #(
		.CYC_W (ptc_pkg::CYC_W),
		.STP_W (ptc_pkg::STEPS_W)
	) u_timer (
		.ref_clk     (ref_clk),
		.arst_n      (arst_n),
		.restart     (st_idle || !run || (st_wait && !wait_enable_bit)),
		.step_cycles (st_wait ? wait_cyc : sample_cyc),
		.steps       (st_wait ? wait_steps : sample_steps),
		.done        (phase_done)
	);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state         <= ptc_pkg::PTC_IDLE;
			osc_adc_on    <= 1'b0;
			detect_active <= 1'b0;
			wait_active   <= 1'b0;
			sample_end    <= 1'b0;
			apc_enable    <= 1'b1;
		end else begin
			state         <= next_state;
			osc_adc_on    <= power_on_bit;
			detect_active <= (next_state == ptc_pkg::PTC_SAMPLE);
			wait_active   <= (next_state == ptc_pkg::PTC_WAIT);
			sample_end    <= st_sample && phase_done && run;
			apc_enable    <= apc_on;
		end
	end

	// ****************************************
	// threshold compare
	// ****************************************
	// full width thresholds with pulse control on, low bytes with it off
	wire [13:0] cmp_val = apc_on ? prox_result :
		{6'h00, prox_result[ptc_pkg::SHORT_LSB +: 8]};
	wire [13:0] lo_cmp  = apc_on ? lo_active : {6'h00, lo_lsb};
	wire [13:0] hi_cmp  = apc_on ? hi_active : {6'h00, hi_lsb};
	wire below   = cmp_val < lo_cmp;
	wire above   = cmp_val > hi_cmp;
	wire out_rng = below || above;
	wire take    = prox_valid && run;

	// ****************************************
	// persistence filter
	// ****************************************
	logic [3:0] persistence_filter_cnt;
	wire [3:0] next_cnt = !out_rng ? 4'h0 :
		((persistence_filter_cnt == persistence_field) ? persistence_filter_cnt : persistence_filter_cnt + 4'h1);
	wire met = (persistence_field == 4'h0) ||
		(out_rng && next_cnt == persistence_field);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			persistence_filter_cnt    <= 4'h0;
			prox_event  <= 1'b0;
			low_breach  <= 1'b0;
			high_breach <= 1'b0;
		end else begin
			if (take) persistence_filter_cnt <= next_cnt;
			prox_event  <= take && met;
			low_breach  <= take && below && met;
			high_breach <= take && above && met;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	logic [31:0] samp_len;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) samp_len <= 32'h0;
		else if (!st_sample || phase_done) samp_len <= 32'h0;
		else samp_len <= samp_len + 32'h1;
	end

	osc_start_a: assert property (
		$rose(osc_adc_on) |-> $past(wr_enable && reg_wdata[0], 2))
		else $error("oscillator on without power-on write");
	detect_stop_a: assert property (
		!detect_enable_bit |=> !detect_active && !wait_active)
		else $error("detection running while disabled");
	wait_gate_a: assert property (
		$rose(wait_active) |-> $past(wait_enable_bit && sample_end == 1'b0))
		else $error("wait phase without wait enable");
	sample_len_a: assert property (
		st_sample && phase_done |->
		samp_len + 32'h1 == 32'(sample_steps) * 32'(SAMPLE_STEP_CYC))
		else $error("sample length wrong");
	thr_latch_a: assert property (
		wr_lo_msb |=> lo_active == {$past(reg_wdata[5:0]), $past(lo_lsb)})
		else $error("threshold not latched as pair");
	lsb_hold_a: assert property (
		wr_lo_lsb && !wr_lo_msb |=> $stable(lo_active))
		else $error("low byte reached active threshold early");
	low_cause_a: assert property (
		low_breach |-> $past(take && cmp_val < lo_cmp))
		else $error("low breach without low result");
	high_cause_a: assert property (
		high_breach |-> $past(take && cmp_val > hi_cmp))
		else $error("high breach without high result");
	persistence_filter_clear_a: assert property (
		take && !out_rng |=> persistence_filter_cnt == 4'h0)
		else $error("counter not cleared inside window");
	event_cause_a: assert property (
		prox_event && $past(persistence_field) != 4'h0 |->
		$past(out_rng) && $past(next_cnt) == $past(persistence_field))
		else $error("event before persistence reached");
	short_fmt_a: assert property (
		take && !apc_on && prox_result[9:2] < lo_lsb
		&& persistence_field == 4'h1 |=> low_breach)
		else $error("short format compare wrong");
	equal_in_a: assert property (
		take && (cmp_val == lo_cmp || cmp_val == hi_cmp) &&
		lo_cmp <= hi_cmp |=> !low_breach && !high_breach)
		else $error("equal result treated as outside");

endmodule
